/* File: include/irp_pkg.sv */
// Shared constants and state types for the two-wire register port.
// Assumes both ends are compiled after this package.
package irp_pkg;

  // ----------------------------------------------------------------
  // Addressing and framing
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR   = 7'h61;
  localparam logic       RW_WRITE   = 1'b0;
  localparam logic       RW_READ    = 1'b1;
  localparam int         BYTE_BITS  = 8;
  localparam int         REG_COUNT  = 32;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_RATE_KHZ = 200000;
  localparam int BUS_RATE_KHZ = 100;
  localparam int QUARTER_CYC  = CLK_RATE_KHZ / (4 * BUS_RATE_KHZ);

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLV_IDLE   = 4'b0000,
    SLV_ADDR   = 4'b0001,
    SLV_AACK   = 4'b0010,
    SLV_INDEX  = 4'b0011,
    SLV_IACK   = 4'b0100,
    SLV_WDATA  = 4'b0101,
    SLV_WACK   = 4'b0110,
    SLV_RDATA  = 4'b0111,
    SLV_RACK   = 4'b1000,
    SLV_IGNORE = 4'b1001
  } irp_slv_e;

  typedef enum logic [2:0] {
    MST_IDLE  = 3'b000,
    MST_START = 3'b001,
    MST_BYTE  = 3'b010,
    MST_STOP  = 3'b011,
    MST_DONE  = 3'b100
  } irp_mst_e;

endpackage

/* File: include/irp_if.sv */
// Two-wire bus between the host end and the register slave end.
// Both lines are open drain with a pull-up; the wire levels are resolved here.
`timescale 1ns/1ps
interface irp_if;
  // Host drive
  logic scl_o;
  logic scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  // Slave drive
  logic s_sda_o;
  logic s_sda_oe;
  // Resolved wire levels
  logic scl;
  logic sda;

  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport host  (output scl_o, scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

/* File: logic/irp_slave.sv */
// Two-wire register slave: address match, index and data writes, reads.
// Assumes a host that keeps the bus protocol and an SCL slow enough for
// several link_clk samples per SCL phase.
`timescale 1ns/1ps
module irp_slave #(
  parameter int         NREG     = irp_pkg::REG_COUNT,
  parameter logic [7:0] OTP_MASK [NREG] = '{default: 8'hFF}
) (
  // System side
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic                below_supply_undervoltage_threshold,
  input  wire logic                otp_load,
  input  wire logic [NREG*8-1:0]   otp_image,
  output logic                     wr_valid,
  output logic [7:0]               wr_index,
  output logic [7:0]               wr_data,
  output logic                     bus_busy,
  // Link side
  input  wire logic                link_clk,
  irp_if.slave                     bus
);

  // The index byte can address at most 256 registers.
  if (NREG < 1 || NREG > 256) begin : g_bad_nreg
    $error("irp_slave: NREG must be 1..256");
  end

  // ----------------------------------------------------------------
  // Link-domain sampling of the pins and system levels
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;
  logic [1:0] uv_sync;
  logic [1:0] load_sync;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync  <= 2'h3;
      sda_sync  <= 2'h3;
      scl_prev  <= 1'b1;
      sda_prev  <= 1'b1;
      uv_sync   <= 2'h0;
      load_sync <= 2'h0;
    end else begin
      scl_sync  <= {scl_sync[0], bus.scl};
      sda_sync  <= {sda_sync[0], bus.sda};
      scl_prev  <= scl_sync[1];
      sda_prev  <= sda_sync[1];
      uv_sync   <= {uv_sync[0], below_supply_undervoltage_threshold};
      load_sync <= {load_sync[0], otp_load};
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_prev;
  assign scl_fall  = ~scl_s & scl_prev;
  assign start_det = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

  // ----------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------
  // Oversampling on link_clk serves every speed class as long as each SCL
  // phase spans a few link_clk periods; no edge of SCL clocks logic.
  irp_pkg::irp_slv_e state;
  logic [3:0]        bitcnt;
  logic [7:0]        shift;
  logic [7:0]        tx;
  logic [7:0]        index;
  logic              rd_dir;
  logic              busy_l;
  logic              sda_oe;
  logic [7:0]        regs [NREG];
  logic              wr_pulse;
  logic              uv;

  assign uv = uv_sync[1];

  // Selected register; an index beyond the store reads as zero.
  logic [7:0] sel_word;

  always_comb begin
    sel_word = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (index == 8'(i)) sel_word = regs[i];
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= irp_pkg::SLV_IDLE;
      bitcnt   <= 4'h0;
      shift    <= 8'h00;
      tx       <= 8'h00;
      index    <= 8'h00;
      rd_dir   <= 1'b0;
      busy_l   <= 1'b0;
      sda_oe   <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (start_det) begin
        // A repeated start is treated exactly like the first one.
        state  <= irp_pkg::SLV_ADDR;
        bitcnt <= 4'h0;
        busy_l <= 1'b1;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        state  <= irp_pkg::SLV_IDLE;
        busy_l <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        if (scl_rise) begin
          // Bits are taken MSB first while SCL is high.
          case (state)
            irp_pkg::SLV_ADDR, irp_pkg::SLV_INDEX, irp_pkg::SLV_WDATA: begin
              shift  <= {shift[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            irp_pkg::SLV_RDATA: bitcnt <= bitcnt + 4'h1;
            irp_pkg::SLV_RACK:  rd_dir <= ~sda_s;
            default: ;
          endcase
        end
        if (scl_fall) begin
          // SDA changes happen just after SCL has fallen, except the supply release below.
          case (state)
            irp_pkg::SLV_ADDR: begin
              if (bitcnt == 4'(irp_pkg::BYTE_BITS)) begin
                if (shift[7:1] == irp_pkg::DEV_ADDR) begin
                  state  <= irp_pkg::SLV_AACK;
                  rd_dir <= (shift[0] == irp_pkg::RW_READ);
                  sda_oe <= 1'b1;
                end else begin
                  state <= irp_pkg::SLV_IGNORE;
                end
              end
            end
            irp_pkg::SLV_INDEX: begin
              if (bitcnt == 4'(irp_pkg::BYTE_BITS)) begin
                index  <= shift;
                state  <= irp_pkg::SLV_IACK;
                sda_oe <= 1'b1;
              end
            end
            irp_pkg::SLV_WDATA: begin
              if (bitcnt == 4'(irp_pkg::BYTE_BITS)) begin
                index    <= index + 8'h01;
                wr_pulse <= 1'b1;
                state    <= irp_pkg::SLV_WACK;
                sda_oe   <= 1'b1;
              end
            end
            irp_pkg::SLV_AACK: begin
              bitcnt <= 4'h0;
              if (rd_dir) begin
                tx     <= sel_word;
                sda_oe <= ~sel_word[7];
                state  <= irp_pkg::SLV_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state  <= irp_pkg::SLV_INDEX;
              end
            end
            irp_pkg::SLV_IACK, irp_pkg::SLV_WACK: begin
              bitcnt <= 4'h0;
              sda_oe <= 1'b0;
              state  <= irp_pkg::SLV_WDATA;
            end
            irp_pkg::SLV_RDATA: begin
              if (bitcnt == 4'(irp_pkg::BYTE_BITS)) begin
                sda_oe <= 1'b0;  // Host owns the acknowledge slot.
                state  <= irp_pkg::SLV_RACK;
              end else begin
                sda_oe <= ~tx[3'(7 - bitcnt)];
              end
            end
            irp_pkg::SLV_RACK: begin
              bitcnt <= 4'h0;
              if (rd_dir) begin
                // Same register again: the index stays put on reads.
                tx     <= sel_word;
                sda_oe <= ~sel_word[7];
                state  <= irp_pkg::SLV_RDATA;
              end else begin
                state <= irp_pkg::SLV_IGNORE;
              end
            end
            default: sda_oe <= 1'b0;
          endcase
        end
        // The supply check overrides any drive at once.
        if (uv) begin
          sda_oe <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register store
  // ----------------------------------------------------------------
  // The load level is quasi-static, so the image is stable while sampled.
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NREG; i++) regs[i] <= irp_pkg::REG_RESET;
    end else if (load_sync[1]) begin
      for (int i = 0; i < NREG; i++) begin
        regs[i] <= (otp_image[i*8 +: 8] & OTP_MASK[i]) | (regs[i] & ~OTP_MASK[i]);
      end
    end else if (wr_pulse) begin
      for (int i = 0; i < NREG; i++) begin
        if (index - 8'h01 == 8'(i)) regs[i] <= shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossing of write events and busy into the system domain
  // ----------------------------------------------------------------
  logic       wr_tog;
  logic [7:0] hold_index;
  logic [7:0] hold_data;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_tog     <= 1'b0;
      hold_index <= 8'h00;
      hold_data  <= 8'h00;
    end else if (wr_pulse) begin
      wr_tog     <= ~wr_tog;
      hold_index <= index - 8'h01;
      hold_data  <= shift;
    end
  end

  logic [2:0] tog_sync;
  logic [1:0] busy_sync;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_sync  <= 3'h0;
      busy_sync <= 2'h0;
      bus_busy  <= 1'b0;
      wr_valid  <= 1'b0;
      wr_index  <= 8'h00;
      wr_data   <= 8'h00;
    end else begin
      tog_sync  <= {tog_sync[1:0], wr_tog};
      busy_sync <= {busy_sync[0], busy_l};
      bus_busy  <= busy_sync[1];
      wr_valid  <= tog_sync[2] ^ tog_sync[1];
      if (tog_sync[2] ^ tog_sync[1]) begin
        wr_index <= hold_index;
        wr_data  <= hold_data;
      end
    end
  end

  // Open drain: only the enable moves; the driven level is always low.
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_oe;

endmodule

/* File: logic/irp_master.sv */
// Host end: issues register writes and index-then-read sequences.
// Assumes a slave that keeps the bus protocol; SCL is divided from clk.
`timescale 1ns/1ps
module irp_master #(
  parameter int QUARTER = irp_pkg::QUARTER_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_index,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  // Result
  output logic            done,
  output logic            nack_err,
  output logic [7:0]      rdata,
  // Bus
  irp_if.host             bus
);

  // The divider is 16 bits wide and needs a few clocks per quarter bit.
  if (QUARTER < 4 || QUARTER > 65536) begin : g_bad_quarter
    $error("irp_master: QUARTER must be 4..65536");
  end

  // ----------------------------------------------------------------
  // Quarter-bit tick and SDA sampling
  // ----------------------------------------------------------------
  logic [15:0] div;
  logic        tick;
  logic [1:0]  sda_sync;

  assign tick = (div == 16'(QUARTER - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div      <= 16'h0000;
      sda_sync <= 2'h3;
    end else begin
      div      <= tick ? 16'h0000 : div + 16'h0001;
      sda_sync <= {sda_sync[0], bus.sda};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Byte slots: 0 address+write, 1 index, 2 data or address+read,
  // 3 read byte. A read inserts a repeated start before slot 2.
  irp_pkg::irp_mst_e state;
  logic [1:0]        ph;
  logic [3:0]        bitn;
  logic [1:0]        slot;
  logic              rd;
  logic [7:0]        idx;
  logic [7:0]        wdat;
  logic [7:0]        shift;
  logic              scl_low;
  logic              sda_low;
  logic [7:0]        tx;
  logic              rx_slot;

  assign rx_slot = (slot == 2'h3);

  always_comb begin
    case (slot)
      2'h0:    tx = {irp_pkg::DEV_ADDR, irp_pkg::RW_WRITE};
      2'h1:    tx = idx;
      2'h2:    tx = rd ? {irp_pkg::DEV_ADDR, irp_pkg::RW_READ} : wdat;
      default: tx = 8'hFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= irp_pkg::MST_IDLE;
      ph        <= 2'h0;
      bitn      <= 4'h0;
      slot      <= 2'h0;
      rd        <= 1'b0;
      idx       <= 8'h00;
      wdat      <= 8'h00;
      shift     <= 8'h00;
      scl_low   <= 1'b0;
      sda_low   <= 1'b0;
      cmd_ready <= 1'b1;
      done      <= 1'b0;
      nack_err  <= 1'b0;
      rdata     <= 8'h00;
    end else begin
      done <= 1'b0;
      case (state)
        irp_pkg::MST_IDLE: begin
          if (cmd_valid) begin
            rd        <= cmd_read;
            idx       <= cmd_index;
            wdat      <= cmd_wdata;
            slot      <= 2'h0;
            ph        <= 2'h0;
            nack_err  <= 1'b0;
            cmd_ready <= 1'b0;
            state     <= irp_pkg::MST_START;
          end
        end
        irp_pkg::MST_START: if (tick) begin
          // Release both, then SDA falls while SCL is high.
          ph <= ph + 2'h1;
          case (ph)
            2'h0:    sda_low <= 1'b0;
            2'h1:    scl_low <= 1'b0;
            2'h2:    sda_low <= 1'b1;
            default: begin
              scl_low <= 1'b1;
              bitn    <= 4'h0;
              state   <= irp_pkg::MST_BYTE;
            end
          endcase
        end
        irp_pkg::MST_BYTE: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            // Data changes only with SCL low; read byte and acks release SDA.
            2'h0:    sda_low <= (bitn < 4'h8) && !rx_slot && !tx[3'(7 - bitn)];
            2'h1:    scl_low <= 1'b0;
            2'h2:    ;
            default: begin
              scl_low <= 1'b1;
              bitn    <= bitn + 4'h1;
              if (bitn < 4'h8) begin
                shift <= {shift[6:0], sda_sync[1]};
              end else if (rx_slot) begin
                // Single-byte read ends with a released acknowledge.
                rdata <= shift;
                state <= irp_pkg::MST_STOP;
              end else if (sda_sync[1]) begin
                nack_err <= 1'b1;
                state    <= irp_pkg::MST_STOP;
              end else if (slot == 2'h1 && rd) begin
                // Index written first, then restart for reading.
                slot  <= 2'h2;
                state <= irp_pkg::MST_START;
              end else if (slot == 2'h2 && !rd) begin
                state <= irp_pkg::MST_STOP;
              end else begin
                slot <= slot + 2'h1;
                bitn <= 4'h0;
              end
            end
          endcase
        end
        irp_pkg::MST_STOP: if (tick) begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0:    sda_low <= 1'b1;
            2'h1:    scl_low <= 1'b0;
            2'h2:    sda_low <= 1'b0;
            default: state   <= irp_pkg::MST_DONE;
          endcase
        end
        irp_pkg::MST_DONE: begin
          done      <= 1'b1;
          cmd_ready <= 1'b1;
          state     <= irp_pkg::MST_IDLE;
        end
        default: state <= irp_pkg::MST_IDLE;
      endcase
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = scl_low;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_low;

endmodule

/* File: tb/irp_properties.sv */
// Concurrent checks on the two-wire bus between the host and slave ends.
// Assumes the bench wires it by name beside the interface that joins them.
`timescale 1ns/1ps
module irp_properties (
  // Clocks and reset
  input wire logic clk,
  input wire logic link_clk,
  input wire logic arst_n,
  // Bus wires and drives
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  // Slave status
  input wire logic bus_busy,
  input wire logic below_supply_undervoltage_threshold
);
  // ----------------------------------------------------------------
  // Bit tracking
  // ----------------------------------------------------------------
  // The ninth rising SCL after a start is an acknowledge slot.
  logic       scl_q;
  logic       sda_q;
  logic [3:0] uv_hist;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       first;
  logic       rd;
  logic       scl_rise;

  assign scl_rise = scl & ~scl_q;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      uv_hist <= 4'h0;
    end else begin
      scl_q   <= scl;
      sda_q   <= sda;
      uv_hist <= {uv_hist[2:0], below_supply_undervoltage_threshold};
    end
  end

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      first   <= 1'b0;
      rd      <= 1'b0;
    end else if (scl && scl_q && sda_q && !sda) begin
      bit_cnt <= 4'h0;
      first   <= 1'b1;
    end else if (scl_rise) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      shift   <= {shift[6:0], sda};
      if (bit_cnt == 4'h8) begin
        first <= 1'b0;
      end
      if (bit_cnt == 4'h7 && first) begin
        rd <= sda;
      end
    end
  end

  a_slave_sda_change: assert property (
    @(posedge link_clk) disable iff (!arst_n) $changed(s_sda_oe) |-> !scl)
    else $error("Slave SDA drive changed while SCL high.");
  a_start_busy: assert property (
    @(posedge clk) disable iff (!arst_n) scl && $fell(sda) |-> ##[1:30] bus_busy)
    else $error("Start not followed by busy.");
  a_stop_free: assert property (
    @(posedge clk) disable iff (!arst_n) scl && $rose(sda) |-> ##[1:30] !bus_busy)
    else $error("Stop not followed by free bus.");
  a_ack_hold: assert property (
    @(posedge link_clk) disable iff (!arst_n) scl_rise && s_sda_oe |=> s_sda_oe [*8])
    else $error("Slave released SDA during a high SCL phase.");
  a_uv_silent: assert property (
    @(posedge link_clk) disable iff (!arst_n)
    below_supply_undervoltage_threshold [*5] |-> !s_sda_oe)
    else $error("Slave drove SDA in undervoltage.");
  a_ninth_release: assert property (
    @(posedge link_clk) disable iff (!arst_n) scl_rise && bit_cnt == 4'h8 |-> !m_sda_oe)
    else $error("Host drove SDA in an acknowledge slot.");
  a_addr_ack: assert property (
    @(posedge link_clk) disable iff (!arst_n) scl_rise && bit_cnt == 4'h8 && first &&
    shift[7:1] == irp_pkg::DEV_ADDR && uv_hist == 4'h0 |-> s_sda_oe)
    else $error("Own address not acknowledged.");
  a_data_ack: assert property (
    @(posedge link_clk) disable iff (!arst_n) scl_rise && bit_cnt == 4'h8 && !first &&
    !rd && uv_hist == 4'h0 |-> s_sda_oe)
    else $error("Written byte not acknowledged.");
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench: host end and slave end joined on one bus.
// Assumes the package, interface and both design modules are compiled first.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic       rd;
    logic [7:0] idx;
    logic [7:0] dat;
  } irp_row_s;

  localparam int NROW = 8;
  // Read rows carry the expected data, write rows the data to send.
  irp_row_s rows [NROW] = '{
    '{1'b1, 8'h05, 8'h00}, '{1'b0, 8'h05, 8'hA5}, '{1'b0, 8'h06, 8'h3C},
    '{1'b1, 8'h05, 8'hA5}, '{1'b1, 8'h06, 8'h3C}, '{1'b0, 8'h1F, 8'hFF},
    '{1'b1, 8'h1F, 8'hFF}, '{1'b1, 8'h28, 8'h00}
  };

  logic                              clk;
  logic                              link_clk;
  logic                              arst_n;
  logic                              cmd_valid;
  logic                              cmd_read;
  logic [7:0]                        cmd_index;
  logic [7:0]                        cmd_wdata;
  logic                              cmd_ready;
  logic                              done;
  logic                              nack_err;
  logic [7:0]                        rdata;
  logic                              below;
  logic                              otp_load;
  logic [irp_pkg::REG_COUNT*8-1:0]   otp_image;
  logic                              wr_valid;
  logic [7:0]                        wr_index;
  logic [7:0]                        wr_data;
  logic                              bus_busy;
  int                                num_errors = 0;
  int                                checked = 0;
  int                                cycles = 0;
  int                                wr_cnt = 0;
  int                                w0;

  irp_if bus ();

  irp_master #(.QUARTER(20)) i_irp_master (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .done(done), .nack_err(nack_err), .rdata(rdata), .bus(bus)
  );

  irp_slave i_irp_slave (
    .clk(clk), .arst_n(arst_n), .below_supply_undervoltage_threshold(below),
    .otp_load(otp_load), .otp_image(otp_image), .wr_valid(wr_valid),
    .wr_index(wr_index), .wr_data(wr_data), .bus_busy(bus_busy),
    .link_clk(link_clk), .bus(bus)
  );

  irp_properties i_irp_properties (
    .clk(clk), .link_clk(link_clk), .arst_n(arst_n), .scl(bus.scl), .sda(bus.sda),
    .m_sda_oe(bus.m_sda_oe), .s_sda_oe(bus.s_sda_oe), .bus_busy(bus_busy),
    .below_supply_undervoltage_threshold(below)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Offset so the two clocks never share an edge pattern.
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #7.5 link_clk = ~link_clk;
  end

  // Counted on the falling edge, where the design's outputs have settled.
  always @(negedge clk) begin
    cycles++;
    if (wr_valid === 1'b1) begin
      wr_cnt++;
    end
    if (cycles == 80000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run_cmd(input logic rd, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_read  = rd;
    cmd_index = idx;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (200) @(negedge clk);
    chk({7'h00, bus_busy}, 8'h01);
    n = 0;
    while (done !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, done}, 8'h01);
    repeat (40) @(negedge clk);
    chk({7'h00, bus_busy}, 8'h00);
  endtask

  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_index = 8'h00;
    cmd_wdata = 8'h00;
    below = 1'b0;
    otp_load = 1'b0;
    for (int i = 0; i < irp_pkg::REG_COUNT; i++) begin
      otp_image[i*8 +: 8] = 8'h80 + 8'(i);
    end
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    for (int r = 0; r < NROW; r++) begin
      w0 = wr_cnt;
      run_cmd(rows[r].rd, rows[r].idx, rows[r].dat);
      chk({7'h00, nack_err}, 8'h00);
      if (rows[r].rd) begin
        chk(rdata, rows[r].dat);
      end else begin
        chk(8'(wr_cnt - w0), 8'h01);
        chk(wr_index, rows[r].idx);
        chk(wr_data, rows[r].dat);
      end
    end
    // A write made in undervoltage must be neither answered nor stored.
    w0 = wr_cnt;
    below = 1'b1;
    repeat (10) @(negedge clk);
    run_cmd(1'b0, 8'h07, 8'h55);
    chk({7'h00, nack_err}, 8'h01);
    chk(8'(wr_cnt - w0), 8'h00);
    below = 1'b0;
    run_cmd(1'b1, 8'h07, 8'h00);
    chk(rdata, 8'h00);
    // Reset in mid-transfer clears the registers and frees the bus.
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_index = 8'h05;
    cmd_wdata = 8'h11;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (500) @(negedge clk);
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    chk({6'h00, cmd_ready, bus_busy}, 8'h02);
    arst_n = 1'b1;
    repeat (20) @(negedge clk);
    run_cmd(1'b1, 8'h05, 8'h00);
    chk(rdata, irp_pkg::REG_RESET);
    otp_load = 1'b1;
    repeat (20) @(negedge clk);
    otp_load = 1'b0;
    run_cmd(1'b1, 8'h09, 8'h00);
    chk(rdata, 8'h89);
    run_cmd(1'b0, 8'h09, 8'h42);
    run_cmd(1'b1, 8'h09, 8'h00);
    chk(rdata, 8'h42);
    finish_test();
  end
endmodule
